// >>> bdcfg_defines.svh
// Constants of the gate-driver configuration, verify and mask register set:
// word layout, register addresses, writable masks and power-on values.
// Assumes the serial framing logic hands over whole 16-bit words.
//
// Overview of operation
// - High-side drain threshold, 6 bits, 50 mV per step, reset 01 1000.
// - Every serial word carries odd parity in bit 0.
// - On-state open-load limit, 4 bits, (n+1) x 25 mV, reset 1000.
// - Drain check time, 6 bits, 100 ns per step, reset 01 0000.
// - on_open_detect_en enables on-state open-load detection, reset 0.
// - enable_guard_timer activates the enable watchdog, reset 0.
// - offtest_current_sel picks 100 uA (0, default) or 400 uA test current.
// - gate_supply_level picks 8 V (0) or 13 V (1), reset 1.
// - Phase comparator level, 6 bits, n/64 of bridge supply, reset 10 0000.
// - Sense amp offset select, 4 bits, reset code 15.
// - Sense amp gain select, 3 bits, codes to gains 10..50, reset 5.
// - off_open_detect_disable: 0 keeps off-state detection on, reset 0.
// - First verify command word: ten supply checks, each active when 1.
// - Second verify word check bits activate and start their check.
// - offstate_load_phase_select picks phase A (0, default) or B.
// - First result word read-only: connect and disconnect flags, reset 0.
// - First mask word: 1 disables that fault detection, reset 0.
// - Second mask word: 1 disables that fault detection, reset 0.
// - Address in 15:12, write flag in 11, data 10:1; reset to defaults.
`ifndef BDCFG_DEFINES_SVH
`define BDCFG_DEFINES_SVH

// Serial word layout
`define BDCFG_ADDR_MSB 15
`define BDCFG_ADDR_LSB 12
`define BDCFG_WR_BIT 11
`define BDCFG_DATA_MSB 10
`define BDCFG_DATA_LSB 1
`define BDCFG_PAR_BIT 0

// Register addresses
`define BDCFG_ADDR_CFG2 4'h2
`define BDCFG_ADDR_CFG3 4'h3
`define BDCFG_ADDR_CFG4 4'h4
`define BDCFG_ADDR_CFG5 4'h5
`define BDCFG_ADDR_VCMD0 4'h6
`define BDCFG_ADDR_VCMD1 4'h7
`define BDCFG_ADDR_VRES0 4'h8
`define BDCFG_ADDR_VRES1 4'h9
`define BDCFG_ADDR_MASK0 4'ha
`define BDCFG_ADDR_MASK1 4'hb

// Writable bits of the 10-bit payload (payload bit k is word bit k+1)
`define BDCFG_WM_CFG2 10'h03f
`define BDCFG_WM_CFG3 10'h3ff
`define BDCFG_WM_CFG4 10'h3ff
`define BDCFG_WM_CFG5 10'h1f7
`define BDCFG_WM_VCMD0 10'h3ff
`define BDCFG_WM_VCMD1 10'h3ef
`define BDCFG_WM_MASK0 10'h3cf
`define BDCFG_WM_MASK1 10'h3cf

// Power-on values of the payload
`define BDCFG_RST_CFG2 10'h018
`define BDCFG_RST_CFG3 10'h210
`define BDCFG_RST_CFG4 10'h060
`define BDCFG_RST_CFG5 10'h0f5
`define BDCFG_RST_ZERO 10'h000

// Payload positions of the check bits that start a check when written 1
`define BDCFG_VCMD1_START_HI 8
`define BDCFG_VCMD1_START_LO 3

`endif

// >>> bdcfg_host.sv
// Host model: frames one request into a serial word with odd parity.
// Assumes the bench holds req and its fields between falling edges.
`timescale 1ns/100ps
`default_nettype none
module bdcfg_host (
    input wire logic req,
    input wire logic [3:0] addr,
    input wire logic wr,
    input wire logic [9:0] data,
    input wire logic bad,
    output logic word_valid,
    output logic [15:0] word_in
);
    logic [15:0] word;
    // A bad word flips parity so that refusal can be exercised
    assign word = {addr, wr, data, ~^{addr, wr, data} ^ bad};
    assign word_valid = req;
    // Idle bus shows the inverse, which keeps odd parity; only word_valid low marks it stale
    assign word_in = req ? word : ~word;
endmodule // bdcfg_host
`default_nettype wire

// >>> bdcfg_pkg.sv
// Types of the gate-driver configuration, verify and mask register set.
// Assumes bdcfg_defines.svh for all numeric layout.
package bdcfg_pkg;

    typedef logic [9:0] bdcfg_data_t;

    // Decoded settings that steer the driver
    typedef struct packed {
        logic [5:0] hs_drain_threshold;
        logic [3:0] on_load_limit;
        logic [5:0] drain_check_time;
        logic on_open_detect_en;
        logic enable_guard_timer;
        logic offtest_current_sel;
        logic gate_supply_level;
        logic [5:0] phase_compare_level;
        logic off_open_detect_disable;
        logic [3:0] amp_offset_sel;
        logic [2:0] amp_gain_sel;
        logic offstate_load_phase_select;
        logic [9:0] chk_supply;
        logic [7:0] chk_bridge;
        logic [7:0] msk_gate;
        logic [7:0] msk_drain;
    } bdcfg_cfg_s;

    // Verification results from the monitors
    typedef struct packed {
        logic res_phb_connect;
        logic res_pha_connect;
        logic res_bridge_disconnect;
        logic res_sense_b_disc;
        logic res_sense_a_disc;
        logic res_phb_state;
        logic res_pha_state;
        logic res_amp_b_disc;
        logic res_amp_a_disc;
    } bdcfg_res_s;

endpackage

// >>> bdcfg_regs.sv
// Serial-word register set: config words 2 to 5, verify commands,
// verify results and fault masks of a full-bridge gate driver.
// Assumes framing logic on clk delivers one whole received word per
// word_valid pulse and sends back reply_word when reply_valid pulses.
`timescale 1ns/100ps
`default_nettype none
`include "bdcfg_defines.svh"

module bdcfg_regs
    import bdcfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic word_valid,
    input wire logic [15:0] word_in,
    input wire bdcfg_res_s results,
    output logic reply_valid,
    output logic [15:0] reply_word,
    output logic parity_error,
    output logic [7:0] verify_start,
    output bdcfg_cfg_s cfg
);

    function automatic bdcfg_data_t wr_mask(input logic [3:0] a);
        case (a)
            `BDCFG_ADDR_CFG2: wr_mask = `BDCFG_WM_CFG2;
            `BDCFG_ADDR_CFG3: wr_mask = `BDCFG_WM_CFG3;
            `BDCFG_ADDR_CFG4: wr_mask = `BDCFG_WM_CFG4;
            `BDCFG_ADDR_CFG5: wr_mask = `BDCFG_WM_CFG5;
            `BDCFG_ADDR_VCMD0: wr_mask = `BDCFG_WM_VCMD0;
            `BDCFG_ADDR_VCMD1: wr_mask = `BDCFG_WM_VCMD1;
            `BDCFG_ADDR_MASK0: wr_mask = `BDCFG_WM_MASK0;
            `BDCFG_ADDR_MASK1: wr_mask = `BDCFG_WM_MASK1;
            default: wr_mask = `BDCFG_RST_ZERO;
        endcase
    endfunction

    function automatic bdcfg_data_t rst_val(input logic [3:0] a);
        case (a)
            `BDCFG_ADDR_CFG2: rst_val = `BDCFG_RST_CFG2;
            `BDCFG_ADDR_CFG3: rst_val = `BDCFG_RST_CFG3;
            `BDCFG_ADDR_CFG4: rst_val = `BDCFG_RST_CFG4;
            `BDCFG_ADDR_CFG5: rst_val = `BDCFG_RST_CFG5;
            default: rst_val = `BDCFG_RST_ZERO;
        endcase
    endfunction

    logic [3:0] addr;
    logic wr_flag;
    bdcfg_data_t wdata;
    logic par_ok;
    logic take;
    bdcfg_data_t res0_word;
    bdcfg_data_t res1_word;
    bdcfg_data_t regs [16];
    bdcfg_data_t rd_data;
    logic [14:0] next_reply;

    assign addr = word_in[`BDCFG_ADDR_MSB:`BDCFG_ADDR_LSB];
    assign wr_flag = word_in[`BDCFG_WR_BIT];
    assign wdata = word_in[`BDCFG_DATA_MSB:`BDCFG_DATA_LSB];
    // Odd count of ones over all sixteen bits means the word is intact
    assign par_ok = ^word_in;
    assign take = word_valid && par_ok;

    // Unused result positions are held at zero
    assign res0_word = {4'h0, results.res_phb_connect,
                        results.res_pha_connect,
                        results.res_bridge_disconnect, 1'b0,
                        results.res_sense_b_disc,
                        results.res_sense_a_disc};
    assign res1_word = {5'h00, results.res_phb_state,
                        results.res_pha_state, 1'b0,
                        results.res_amp_b_disc,
                        results.res_amp_a_disc};

    // One storage word per address; result words follow the monitors and
    // ignore writes, writable words keep only their defined bits.
    genvar gi;
    for (gi = 0; gi < 16; gi++) begin : g_reg
        localparam logic [3:0] A = 4'(gi);
        if (A == `BDCFG_ADDR_VRES0 || A == `BDCFG_ADDR_VRES1) begin : g_ro
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    regs[gi] <= `BDCFG_RST_ZERO;
                end else if (A == `BDCFG_ADDR_VRES0) begin
                    regs[gi] <= res0_word;
                end else begin
                    regs[gi] <= res1_word;
                end
            end
        end else begin : g_rw
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    regs[gi] <= rst_val(A);
                end else if (take && wr_flag && addr == A) begin
                    regs[gi] <= wdata & wr_mask(A);
                end
            end
        end
    end

    assign rd_data = regs[addr];

    // Reply echoes the address and the content held before any write
    assign next_reply = {addr, 1'b0, rd_data};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reply_valid <= 1'b0;
            reply_word <= 16'h0001;
        end else begin
            reply_valid <= take;
            if (take) begin
                reply_word <= {next_reply, ~^next_reply};
            end
        end
    end

    // A corrupted word is dropped whole; parity_error flags it on the next cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            parity_error <= 1'b0;
        end else begin
            parity_error <= word_valid && !par_ok;
        end
    end

    // Each bridge check bit written 1 also launches its check, one pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            verify_start <= 8'h00;
        end else if (take && wr_flag && addr == `BDCFG_ADDR_VCMD1) begin
            verify_start <= {wdata[`BDCFG_VCMD1_START_HI:5],
                             wdata[`BDCFG_VCMD1_START_LO:0]};
        end else begin
            verify_start <= 8'h00;
        end
    end

    // Settings straight from the storage flops
    assign cfg.hs_drain_threshold = regs[2][5:0];
    assign cfg.on_load_limit = regs[3][9:6];
    assign cfg.drain_check_time = regs[3][5:0];
    assign cfg.on_open_detect_en = regs[4][9];
    assign cfg.enable_guard_timer = regs[4][8];
    assign cfg.offtest_current_sel = regs[4][7];
    assign cfg.gate_supply_level = regs[4][6];
    assign cfg.phase_compare_level = regs[4][5:0];
    assign cfg.off_open_detect_disable = regs[5][8];
    assign cfg.amp_offset_sel = regs[5][7:4];
    assign cfg.amp_gain_sel = regs[5][2:0];
    assign cfg.offstate_load_phase_select = regs[7][9];
    assign cfg.chk_supply = regs[6];
    assign cfg.chk_bridge = {regs[7][8:5], regs[7][3:0]};
    assign cfg.msk_gate = {regs[10][9:6], regs[10][3:0]};
    assign cfg.msk_drain = {regs[11][9:6], regs[11][3:0]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Framing and parity of each word
    reply_parity_a: assert property (
        reply_valid |-> ^reply_word)
        else $error("reply word has even parity");

    bad_parity_a: assert property (
        word_valid && !(^word_in)
        |=> parity_error && !reply_valid)
        else $error("bad parity word was answered");

    bad_no_write_a: assert property (
        word_valid && !(^word_in)
        |=> $stable(cfg))
        else $error("bad parity word changed a setting");

    bad_no_start_a: assert property (
        word_valid && !(^word_in)
        |=> verify_start == 8'h00)
        else $error("bad parity word started a check");

    err_only_bad_a: assert property (
        !(word_valid && !(^word_in))
        |=> !parity_error)
        else $error("parity error without a bad word");

    // Reply layout and timing
    reply_addr_a: assert property (
        take
        |=> reply_valid && reply_word[15:12] == $past(addr))
        else $error("reply missing or wrong address");

    reply_flag_a: assert property (
        reply_valid |-> !reply_word[`BDCFG_WR_BIT])
        else $error("reply carries a write flag");

    reply_data_a: assert property (
        take
        |=> reply_word[`BDCFG_DATA_MSB:`BDCFG_DATA_LSB] == $past(rd_data))
        else $error("reply does not carry the old content");

    reply_only_a: assert property (
        !take |=> !reply_valid)
        else $error("reply without a taken word");

    reply_hold_a: assert property (
        !reply_valid |-> $stable(reply_word))
        else $error("reply word changed without a reply");

    // Each field lands where the word layout puts it
    thresh_write_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_CFG2
        |=> cfg.hs_drain_threshold == $past(wdata[5:0]))
        else $error("config word 2 write not stored");

    cfg3_write_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_CFG3
        |=> cfg.on_load_limit == $past(wdata[9:6])
            && cfg.drain_check_time == $past(wdata[5:0]))
        else $error("config word 3 write not stored");

    cfg_write_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_CFG4
        |=> cfg.phase_compare_level == $past(wdata[5:0])
            && cfg.gate_supply_level == $past(wdata[6]))
        else $error("config word 4 write not stored");

    cfg4_flags_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_CFG4
        |=> cfg.on_open_detect_en == $past(wdata[9])
            && cfg.enable_guard_timer == $past(wdata[8])
            && cfg.offtest_current_sel == $past(wdata[7]))
        else $error("config word 4 flags not stored");

    gain_write_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_CFG5
        |=> cfg.amp_gain_sel == $past(wdata[2:0])
            && cfg.amp_offset_sel == $past(wdata[7:4]))
        else $error("config word 5 write not stored");

    detect_off_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_CFG5
        |=> cfg.off_open_detect_disable == $past(wdata[8]))
        else $error("off-state detect bit not stored");

    supply_cmd_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_VCMD0
        |=> cfg.chk_supply == $past(wdata))
        else $error("supply check word not stored");

    bridge_cmd_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_VCMD1
        |=> cfg.chk_bridge == {$past(wdata[8:5]), $past(wdata[3:0])})
        else $error("bridge check bits not stored");

    phase_sel_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_VCMD1
        |=> cfg.offstate_load_phase_select == $past(wdata[9]))
        else $error("phase select not stored");

    gate_mask_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_MASK0
        |=> cfg.msk_gate == {$past(wdata[9:6]), $past(wdata[3:0])})
        else $error("first mask word not stored");

    drain_mask_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_MASK1
        |=> cfg.msk_drain == {$past(wdata[9:6]), $past(wdata[3:0])})
        else $error("second mask word not stored");

    // Settings move only on an accepted write
    no_write_hold_a: assert property (
        !(take && wr_flag)
        |=> $stable(cfg.hs_drain_threshold)
            && $stable(cfg.msk_drain))
        else $error("setting changed without a write");

    hold_all_a: assert property (
        !(take && wr_flag) |=> $stable(cfg))
        else $error("settings moved without a write");

    // Check launch pulses
    start_value_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_VCMD1
        |=> verify_start == {$past(wdata[8:5]), $past(wdata[3:0])})
        else $error("check start bits differ from write");

    start_cause_a: assert property (
        verify_start != 8'h00
        |-> $past(take && wr_flag && addr == `BDCFG_ADDR_VCMD1))
        else $error("check start pulse without its write");

    start_pulse_a: assert property (
        !(take && wr_flag && addr == `BDCFG_ADDR_VCMD1)
        |=> verify_start == 8'h00)
        else $error("check start pulse too long");

    start_kept_a: assert property (
        verify_start != 8'h00
        |-> (verify_start & ~cfg.chk_bridge) == 8'h00)
        else $error("started check not left active");

    // Result words follow the monitors and ignore writes
    res0_follow_a: assert property (
        1'b1 |=> regs[`BDCFG_ADDR_VRES0] == $past(res0_word))
        else $error("first result word lags the monitors");

    res1_follow_a: assert property (
        1'b1 |=> regs[`BDCFG_ADDR_VRES1] == $past(res1_word))
        else $error("second result word lags the monitors");

    result_ro_a: assert property (
        take && addr == `BDCFG_ADDR_VRES0
        ##1 take && addr == `BDCFG_ADDR_VRES0
        |=> reply_word[10:1] == $past(res0_word, 2))
        else $error("result word read does not follow monitors");

    ro_write_a: assert property (
        take && wr_flag && addr == `BDCFG_ADDR_VRES0
        |=> regs[`BDCFG_ADDR_VRES0] == $past(res0_word))
        else $error("write reached a result word");

    // Unassigned positions stay zero
    res0_gap_a: assert property (
        reply_valid && reply_word[15:12] == `BDCFG_ADDR_VRES0
        |-> reply_word[10:7] == 4'h0 && !reply_word[3])
        else $error("unassigned result bit read as one");

    res1_gap_a: assert property (
        reply_valid && reply_word[15:12] == `BDCFG_ADDR_VRES1
        |-> reply_word[10:6] == 5'h00 && !reply_word[3])
        else $error("unassigned result bit read as one");

    unused_zero_a: assert property (
        reply_valid && reply_word[15:12] == `BDCFG_ADDR_CFG5
        |-> !reply_word[10] && !reply_word[4])
        else $error("unassigned bit read as one");

    empty_addr_a: assert property (
        regs[0] == `BDCFG_RST_ZERO && regs[1] == `BDCFG_RST_ZERO
        && regs[12] == `BDCFG_RST_ZERO && regs[13] == `BDCFG_RST_ZERO
        && regs[14] == `BDCFG_RST_ZERO && regs[15] == `BDCFG_RST_ZERO)
        else $error("unmapped address holds a one");

    gap_bits_a: assert property (
        regs[2][9:6] == 4'h0 && !regs[7][4]
        && regs[10][5:4] == 2'b00
        && regs[11][5:4] == 2'b00)
        else $error("unassigned stored bit is one");

endmodule // bdcfg_regs

`default_nettype wire

// >>> bdcfg_regs_tb.sv
// Self-checking bench of the register set; the host model frames words.
// Assumes the design files and bdcfg_host.sv are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "bdcfg_defines.svh"
module bdcfg_regs_tb import bdcfg_pkg::*;;
    logic clk = 0, rst_b = 0, req = 0, wr = 0, bad = 0;
    logic [3:0] addr = 4'h0;
    bdcfg_data_t data = 10'h000;
    bdcfg_res_s results = '0;
    logic word_valid, reply_valid, parity_error;
    logic [15:0] word_in, reply_word;
    logic [7:0] verify_start;
    bdcfg_cfg_s cfg;
    bdcfg_data_t mem [16];
    logic [25:0] expq [$];
    int num_errors = 0, n_checks = 0, cycles = 0;

    bdcfg_host host (.req(req), .addr(addr), .wr(wr), .data(data),
        .bad(bad), .word_valid(word_valid), .word_in(word_in));
    bdcfg_regs DUT (.clk(clk), .rst_b(rst_b), .word_valid(word_valid),
        .word_in(word_in), .results(results), .reply_valid(reply_valid),
        .reply_word(reply_word), .parity_error(parity_error),
        .verify_start(verify_start), .cfg(cfg));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(string what, logic [68:0] seen, logic [68:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic bdcfg_data_t wmask(logic [3:0] a);
        case (a)
            4'h2: return `BDCFG_WM_CFG2;
            4'h3: return `BDCFG_WM_CFG3;
            4'h4: return `BDCFG_WM_CFG4;
            4'h5: return `BDCFG_WM_CFG5;
            4'h6: return `BDCFG_WM_VCMD0;
            4'h7: return `BDCFG_WM_VCMD1;
            4'ha: return `BDCFG_WM_MASK0;
            4'hb: return `BDCFG_WM_MASK1;
            default: return 10'h000;
        endcase
    endfunction

    task automatic mem_reset();
        foreach (mem[i]) mem[i] = `BDCFG_RST_ZERO;
        mem[2] = `BDCFG_RST_CFG2;
        mem[3] = `BDCFG_RST_CFG3;
        mem[4] = `BDCFG_RST_CFG4;
        mem[5] = `BDCFG_RST_CFG5;
    endtask

    function automatic bdcfg_data_t rd(logic [3:0] a);
        bdcfg_res_s r;
        r = results;
        if (a == 4'h8) begin
            return {4'h0, r.res_phb_connect, r.res_pha_connect,
                r.res_bridge_disconnect, 1'b0, r.res_sense_b_disc,
                r.res_sense_a_disc};
        end
        if (a == 4'h9) begin
            return {5'h00, r.res_phb_state, r.res_pha_state, 1'b0,
                r.res_amp_b_disc, r.res_amp_a_disc};
        end
        return mem[a];
    endfunction

    function automatic bdcfg_cfg_s exp_cfg();
        bdcfg_cfg_s c;
        c.hs_drain_threshold = mem[2][5:0];
        {c.on_load_limit, c.drain_check_time} = mem[3];
        {c.on_open_detect_en, c.enable_guard_timer, c.offtest_current_sel,
            c.gate_supply_level, c.phase_compare_level} = mem[4];
        c.off_open_detect_disable = mem[5][8];
        c.amp_offset_sel = mem[5][7:4];
        c.amp_gain_sel = mem[5][2:0];
        c.offstate_load_phase_select = mem[7][9];
        c.chk_supply = mem[6];
        c.chk_bridge = {mem[7][8:5], mem[7][3:0]};
        c.msk_gate = {mem[10][9:6], mem[10][3:0]};
        c.msk_drain = {mem[11][9:6], mem[11][3:0]};
        return c;
    endfunction

    // Note the reply before updating, since the reply carries old content
    task automatic send(logic [3:0] a, logic w, bdcfg_data_t d, logic b);
        logic [14:0] u;
        logic [7:0] vs;
        @(negedge clk);
        req = 1;
        addr = a;
        wr = w;
        data = d;
        bad = b;
        u = {a, 1'b0, rd(a)};
        vs = (w && a == 4'h7) ? {d[8:5], d[3:0]} : 8'h00;
        if (b) begin
            expq.push_back({2'b10, 8'h00, 16'h0000});
        end else begin
            expq.push_back({2'b01, vs, u, ~^u});
            if (w) mem[a] = d & wmask(a);
        end
    endtask

    task automatic idle();
        @(negedge clk);
        req = 0;
        repeat (3) @(negedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            end_of_test();
        end
        if (reply_valid === 1'b1 || parity_error === 1'b1) begin
            check("reply", {parity_error, reply_valid, verify_start,
                parity_error ? 16'h0000 : reply_word},
                expq.size() > 0 ? expq.pop_front() : 26'h0);
        end
    end

    initial begin
        void'($urandom(89768));
        mem_reset();
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_b = 1;
        check("cfg", cfg, exp_cfg());
        for (int p = 0; p < 5; p++) begin
            results = bdcfg_res_s'(9'($urandom));
            for (int a = 0; a < 16; a++) send(a[3:0], 1'b0, 10'h000, 1'b0);
            // Back-to-back reads of both result words
            repeat (2) send(4'h8, 1'b0, 10'h000, 1'b0);
            repeat (2) send(4'h9, 1'b0, 10'h000, 1'b0);
            // Back-to-back writes, some with broken parity, all addresses
            for (int a = 0; a < 16 && p < 4; a++) begin
                send(a[3:0], 1'b1, 10'($urandom), p == 2 && a[0]);
            end
            idle();
            check("cfg", cfg, exp_cfg());
        end
        @(negedge clk);
        rst_b = 0;
        @(negedge clk);
        mem_reset();
        check("cfg", cfg, exp_cfg());
        check("reply_word", reply_word, 16'h0001);
        rst_b = 1;
        for (int a = 0; a < 16; a++) send(a[3:0], 1'b0, 10'h000, 1'b0);
        idle();
        check("queue", expq.size(), 0);
        end_of_test();
    end
endmodule // bdcfg_regs_tb
`default_nettype wire
